//--- counter_pkg.sv
package counter_pkg;
  // data and address widths of the register port
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PRESCALE = 8'h04;
  localparam logic [7:0] ADDR_PRESET1 = 8'h08;
  localparam logic [7:0] ADDR_PRESET2 = 8'h0C;
  localparam logic [7:0] ADDR_OUT_TIME = 8'h10;
  localparam logic [7:0] ADDR_COUNT = 8'h14;
  localparam logic [7:0] ADDR_SECOND = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;
  localparam logic [7:0] ADDR_MASK = 8'h20;
  localparam logic [7:0] ADDR_UI = 8'h24;
  // control register field positions
  localparam int CTRL_SOURCING = 0;
  localparam int CTRL_FAST_A = 1;
  localparam int CTRL_FAST_B = 2;
  localparam int CTRL_SINGLE_DIR = 3;
  localparam int CTRL_COUNT_DOWN = 4;
  localparam int CTRL_AUTORST_LO = 5;
  localparam int CTRL_AUTORST_HI = 6;
  localparam int CTRL_FKEY_RESET = 7;
  localparam int CTRL_TOTAL_MODE = 8;
  localparam int CTRL_SCROLL = 9;
  localparam int CTRL_W = 10;
  // automatic reset modes
  localparam logic [1:0] AUTORST_NONE = 2'h0;
  localparam logic [1:0] AUTORST_P1 = 2'h1;
  localparam logic [1:0] AUTORST_P2 = 2'h2;
  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h081;
  localparam logic [31:0] PRESCALE_RESET = 32'h0000_0001;
  localparam logic [31:0] ZERO_RESET = 32'h0000_0000;
  // status bits, also the mask layout
  localparam int ST_MATCH1 = 0;
  localparam int ST_MATCH2 = 1;
  localparam int ST_CYCLE = 2;
  localparam int ST_RESET = 3;
  localparam int ST_W = 4;
  // conditioned input slots
  localparam int NUM_COND = 7;
  localparam int COND_A = 0;
  localparam int COND_B = 1;
  localparam int COND_USER = 2;
  localparam int KEY_FUNC = 3;
  localparam int KEY_MENU = 4;
  localparam int KEY_UP = 5;
  localparam int KEY_RIGHT = 6;
  // timing
  localparam int CLK_HZ = 125_000_000;
  localparam int DEBOUNCE_MS = 10;
  localparam int DEBOUNCE_CYC = (DEBOUNCE_MS * (CLK_HZ / 1000) + 0);
  localparam int EDIT_TIMEOUT_S = 10;
  localparam int EDIT_TIMEOUT_CYC = EDIT_TIMEOUT_S * CLK_HZ;
  localparam int MENU_HOLD_S = 2;
  localparam int MENU_HOLD_CYC = MENU_HOLD_S * CLK_HZ;
  // display range, six digits
  localparam logic [31:0] DISPLAY_MAX = 32'h000F_423F;
  localparam logic [2:0] LAST_DIGIT = 3'h5;
  // secondary display views
  localparam logic [2:0] VIEW_PRESCALE = 3'h0;
  localparam logic [2:0] VIEW_PRESET1 = 3'h1;
  localparam logic [2:0] VIEW_PRESET2 = 3'h2;
  localparam logic [2:0] VIEW_OUT_TIME = 3'h3;
  localparam logic [2:0] VIEW_SECOND = 3'h4;
  // programming menu parameters
  localparam logic [1:0] PARAM_COUNT_INPUT_CONFIG = 2'h0;
  localparam logic [1:0] PARAM_DIR = 2'h1;
  localparam logic [1:0] PARAM_AUTORST = 2'h2;
  localparam logic [1:0] PARAM_ENTRY = 2'h3;
  // front panel modes
  typedef enum logic [1:0] {UI_OPERATE, UI_EDIT, UI_PROG} ui_state_t;
endpackage : counter_pkg

//--- input_conditioner.sv
`timescale 1ns/1ps
module input_conditioner #(
  parameter int FILT_CYC = counter_pkg::DEBOUNCE_CYC
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic pin_i,
  input wire logic invert_i,
  input wire logic filter_i,
  output logic level_o,
  output logic rise_o
);
  localparam int CW = $clog2(FILT_CYC + 1);

  if (FILT_CYC < 2) begin : g_chk
    $error("FILT_CYC must be at least 2");
  end

  logic sync1; // first stage, read only by sync2
  logic sync2; // second stage
  logic [CW-1:0] cnt; // stability counter
  logic [CW-1:0] next_cnt;
  logic next_level;
  logic sampled; // synchronised level after polarity

  // polarity applied after the synchroniser
  assign sampled = sync2 ^ invert_i;

  // filter or bypass
  always_comb begin
    next_cnt = '0;
    next_level = level_o;
    if (!filter_i) begin
      next_level = sampled;
    end else if (sampled != level_o) begin
      if (cnt == CW'(FILT_CYC - 1)) begin
        next_level = sampled;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  // sync, level and edge registers
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      cnt <= '0;
      level_o <= 1'b0;
      rise_o <= 1'b0;
    end else begin
      sync1 <= pin_i;
      sync2 <= sync1;
      cnt <= next_cnt;
      level_o <= next_level;
      rise_o <= next_level & ~level_o;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  chk_fast_bypass: assert property (!filter_i |=> level_o == $past(sampled))
    else $error("bypass did not follow input");
  chk_slow_stable: assert property (
    $past(filter_i) && filter_i && $changed(level_o) |-> $past(cnt) == CW'(FILT_CYC - 1))
    else $error("filtered level changed early");
  chk_sync_edge: assert property (rise_o |-> level_o && !$past(level_o))
    else $error("edge pulse without rising level");
endmodule : input_conditioner

//--- preset_batch_pulse_counter.sv
`timescale 1ns/1ps
module preset_batch_pulse_counter #(
  parameter int DEBOUNCE_CYC = counter_pkg::DEBOUNCE_CYC,
  parameter int MENU_HOLD_CYC = counter_pkg::MENU_HOLD_CYC,
  parameter int EDIT_TIMEOUT_CYC = counter_pkg::EDIT_TIMEOUT_CYC
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic count_a_i,
  input wire logic count_b_i,
  input wire logic user_i,
  input wire logic key_func_i,
  input wire logic key_menu_i,
  input wire logic key_up_i,
  input wire logic key_right_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic [1:0] out_o,
  output logic irq_o,
  output logic [31:0] upper_value_o,
  output logic upper_is_mnemonic_o,
  output logic [31:0] lower_value_o,
  output logic [6:0] annunciator_o,
  output logic [2:0] edit_digit_o,
  output logic edit_active_o
);
  localparam int IW = $clog2(EDIT_TIMEOUT_CYC + 1);
  localparam int HW = $clog2(MENU_HOLD_CYC + 1);

  if (MENU_HOLD_CYC < 2 || EDIT_TIMEOUT_CYC < 2) begin : g_chk
    $error("hold and timeout counts must be at least 2");
  end

  // digit position to decimal weight
  function automatic logic [31:0] digit_weight(input logic [2:0] d);
    case (d)
      3'h0: digit_weight = 32'h0000_0001;
      3'h1: digit_weight = 32'h0000_000A;
      3'h2: digit_weight = 32'h0000_0064;
      3'h3: digit_weight = 32'h0000_03E8;
      3'h4: digit_weight = 32'h0000_2710;
      default: digit_weight = 32'h0001_86A0;
    endcase
  endfunction : digit_weight

  // configuration state
  logic [counter_pkg::CTRL_W-1:0] ctrl, next_ctrl;
  logic [31:0] prescale, next_prescale;
  logic [31:0] preset1, next_preset1;
  logic [31:0] preset2, next_preset2;
  logic [31:0] out_time, next_out_time;
  // counting state
  logic [31:0] count, next_count;
  logic [31:0] second, next_second;
  logic [1:0] next_out;
  logic eq1_q, eq2_q; // last comparison results
  // interrupt state
  logic [counter_pkg::ST_W-1:0] status, next_status;
  logic [counter_pkg::ST_W-1:0] mask, next_mask;
  // front panel state
  counter_pkg::ui_state_t state, next_state;
  logic [2:0] view, next_view;
  logic [2:0] digit, next_digit;
  logic [31:0] edit_val, next_edit;
  logic [IW-1:0] idle, next_idle;
  logic [HW-1:0] hold, next_hold;
  logic [1:0] param, next_param;
  logic ui_commit; // store edited value
  logic ui_opt_step; // step current option
  // conditioned inputs
  logic [counter_pkg::NUM_COND-1:0] cond_pin, cond_inv, cond_filt, lvl, rise;

  // control decodes
  logic single_dir, count_down, total_mode;
  logic [1:0] autorst;
  logic active_low;
  assign single_dir = ctrl[counter_pkg::CTRL_SINGLE_DIR];
  assign count_down = ctrl[counter_pkg::CTRL_COUNT_DOWN];
  assign total_mode = ctrl[counter_pkg::CTRL_TOTAL_MODE];
  assign autorst = ctrl[counter_pkg::CTRL_AUTORST_HI:counter_pkg::CTRL_AUTORST_LO];
  assign active_low = ~ctrl[counter_pkg::CTRL_SOURCING];

  // pin map and per-input options
  assign cond_pin = {key_right_i, key_up_i, key_menu_i, key_func_i, user_i, count_b_i, count_a_i};
  assign cond_inv = {4'h0, active_low, single_dir & active_low, 1'b0};
  assign cond_filt = {5'h1F, ~ctrl[counter_pkg::CTRL_FAST_B], ~ctrl[counter_pkg::CTRL_FAST_A]};

  // one conditioner per input
  for (genvar i = 0; i < counter_pkg::NUM_COND; i++) begin : g_cond
    input_conditioner #(.FILT_CYC(DEBOUNCE_CYC)) u_cond (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .pin_i(cond_pin[i]),
      .invert_i(cond_inv[i]),
      .filter_i(cond_filt[i]),
      .level_o(lvl[i]),
      .rise_o(rise[i])
    );
  end

  // event decodes
  logic count_edge, dir_down, manual_reset, match1_ev, match2_ev;
  logic auto_reset, any_reset, cycle_done, any_key, bus_wr_second;
  assign count_edge = rise[counter_pkg::COND_A];
  assign dir_down = single_dir ? count_down : lvl[counter_pkg::COND_B];
  assign manual_reset = rise[counter_pkg::COND_USER] | (single_dir & rise[counter_pkg::COND_B])
    | (rise[counter_pkg::KEY_FUNC] & ctrl[counter_pkg::CTRL_FKEY_RESET]);
  assign match1_ev = (count == preset1) & ~eq1_q;
  assign match2_ev = (count == preset2) & ~eq2_q;
  assign auto_reset = (autorst == counter_pkg::AUTORST_P1 && match1_ev)
    || (autorst == counter_pkg::AUTORST_P2 && match2_ev);
  assign any_reset = manual_reset | auto_reset;
  assign cycle_done = match2_ev;
  assign any_key = |rise[counter_pkg::KEY_RIGHT:counter_pkg::KEY_FUNC];
  assign bus_wr_second = wr_i && addr_i == counter_pkg::ADDR_SECOND;

  // value shown in the secondary view
  logic [31:0] view_value;
  always_comb begin
    case (view)
      counter_pkg::VIEW_PRESCALE: view_value = prescale;
      counter_pkg::VIEW_PRESET1: view_value = preset1;
      counter_pkg::VIEW_PRESET2: view_value = preset2;
      counter_pkg::VIEW_OUT_TIME: view_value = out_time;
      default: view_value = second;
    endcase
  end

  // front panel next state
  always_comb begin
    next_state = state;
    next_view = view;
    next_digit = digit;
    next_edit = edit_val;
    next_idle = idle;
    next_hold = hold;
    next_param = param;
    ui_commit = 1'b0;
    ui_opt_step = 1'b0;
    case (state)
      counter_pkg::UI_OPERATE: begin
        next_hold = lvl[counter_pkg::KEY_MENU] ? hold + 1'b1 : '0;
        if (lvl[counter_pkg::KEY_MENU] && hold == HW'(MENU_HOLD_CYC - 1)) begin
          next_state = counter_pkg::UI_PROG;
          next_param = counter_pkg::PARAM_COUNT_INPUT_CONFIG;
          next_hold = '0;
        end else if (rise[counter_pkg::KEY_MENU]) begin
          // advance secondary view
          next_view = (view == counter_pkg::VIEW_SECOND) ? counter_pkg::VIEW_PRESCALE
            : view + 1'b1;
        end else if ((rise[counter_pkg::KEY_UP] || rise[counter_pkg::KEY_RIGHT])
            && view != counter_pkg::VIEW_SECOND) begin
          next_state = counter_pkg::UI_EDIT;
          next_edit = view_value;
          next_digit = 3'h0;
          next_idle = '0;
        end
      end
      counter_pkg::UI_EDIT: begin
        next_idle = any_key ? '0 : idle + 1'b1;
        if (rise[counter_pkg::KEY_MENU]) begin
          ui_commit = 1'b1;
          next_state = counter_pkg::UI_OPERATE;
        end else if (!any_key && idle == IW'(EDIT_TIMEOUT_CYC - 1)) begin
          next_state = counter_pkg::UI_OPERATE;
        end else if (rise[counter_pkg::KEY_UP]) begin
          // digit step or scroll up, held within range
          if (!ctrl[counter_pkg::CTRL_SCROLL]) begin
            if (edit_val + digit_weight(digit) <= counter_pkg::DISPLAY_MAX) begin
              next_edit = edit_val + digit_weight(digit);
            end
          end else if (edit_val < counter_pkg::DISPLAY_MAX) begin
            next_edit = edit_val + 32'h1;
          end
        end else if (rise[counter_pkg::KEY_RIGHT]) begin
          // digit move or scroll down
          if (!ctrl[counter_pkg::CTRL_SCROLL]) begin
            next_digit = (digit == counter_pkg::LAST_DIGIT) ? 3'h0 : digit + 1'b1;
          end else if (edit_val != 32'h0) begin
            next_edit = edit_val - 32'h1;
          end
        end
      end
      counter_pkg::UI_PROG: begin
        if (rise[counter_pkg::KEY_MENU]) begin
          // next parameter, leave after the last
          if (param == counter_pkg::PARAM_ENTRY) begin
            next_state = counter_pkg::UI_OPERATE;
          end else begin
            next_param = param + 1'b1;
          end
        end else if (rise[counter_pkg::KEY_UP]) begin
          ui_opt_step = 1'b1;
        end
      end
      default: begin
        next_state = counter_pkg::UI_OPERATE;
      end
    endcase
  end

  // configuration next values, bus write wins
  always_comb begin
    next_ctrl = ctrl;
    next_prescale = prescale;
    next_preset1 = preset1;
    next_preset2 = preset2;
    next_out_time = out_time;
    if (ui_commit) begin
      case (view)
        counter_pkg::VIEW_PRESCALE: next_prescale = edit_val;
        counter_pkg::VIEW_PRESET1: next_preset1 = edit_val;
        counter_pkg::VIEW_PRESET2: next_preset2 = edit_val;
        default: next_out_time = edit_val;
      endcase
    end
    if (ui_opt_step) begin
      case (param)
        counter_pkg::PARAM_COUNT_INPUT_CONFIG: next_ctrl[counter_pkg::CTRL_SINGLE_DIR] = ~single_dir;
        counter_pkg::PARAM_DIR: next_ctrl[counter_pkg::CTRL_COUNT_DOWN] = ~count_down;
        counter_pkg::PARAM_AUTORST: begin
          next_ctrl[counter_pkg::CTRL_AUTORST_HI:counter_pkg::CTRL_AUTORST_LO] =
            (autorst == counter_pkg::AUTORST_P2) ? counter_pkg::AUTORST_NONE : autorst + 1'b1;
        end
        default: next_ctrl[counter_pkg::CTRL_SCROLL] = ~ctrl[counter_pkg::CTRL_SCROLL];
      endcase
    end
    if (wr_i) begin
      case (addr_i)
        counter_pkg::ADDR_CTRL: next_ctrl = wdata_i[counter_pkg::CTRL_W-1:0];
        counter_pkg::ADDR_PRESCALE: next_prescale = wdata_i;
        counter_pkg::ADDR_PRESET1: next_preset1 = wdata_i;
        counter_pkg::ADDR_PRESET2: next_preset2 = wdata_i;
        counter_pkg::ADDR_OUT_TIME: next_out_time = wdata_i;
        default: next_ctrl = next_ctrl;
      endcase
    end
  end

  // counters and outputs next values
  always_comb begin
    next_count = count;
    next_second = second;
    next_out = out_o;
    if (any_reset) begin
      next_count = count_down ? preset1 : 32'h0;
      next_out = 2'h0;
    end else if (count_edge) begin
      next_count = dir_down ? count - prescale : count + prescale;
    end
    // output set wins over a reset in the same cycle
    if (match1_ev) begin
      next_out[0] = 1'b1;
    end
    if (match2_ev) begin
      next_out[1] = 1'b1;
    end
    if (bus_wr_second) begin
      next_second = wdata_i;
    end else if (total_mode) begin
      if (count_edge) begin
        next_second = dir_down ? second - prescale : second + prescale;
      end
    end else if (cycle_done) begin
      next_second = second + 32'h1;
    end
  end

  // interrupt next values, set wins over clear
  always_comb begin
    next_mask = mask;
    next_status = status;
    if (wr_i && addr_i == counter_pkg::ADDR_STATUS) begin
      next_status = status & ~wdata_i[counter_pkg::ST_W-1:0];
    end
    if (wr_i && addr_i == counter_pkg::ADDR_MASK) begin
      next_mask = wdata_i[counter_pkg::ST_W-1:0];
    end
    next_status[counter_pkg::ST_MATCH1] = next_status[counter_pkg::ST_MATCH1] | match1_ev;
    next_status[counter_pkg::ST_MATCH2] = next_status[counter_pkg::ST_MATCH2] | match2_ev;
    next_status[counter_pkg::ST_CYCLE] = next_status[counter_pkg::ST_CYCLE] | cycle_done;
    next_status[counter_pkg::ST_RESET] = next_status[counter_pkg::ST_RESET] | any_reset;
  end

  // read data and display next values
  logic [31:0] next_rdata, next_upper, next_lower;
  logic [6:0] next_annun;
  always_comb begin
    next_rdata = 32'h0;
    if (rd_i) begin
      case (addr_i)
        counter_pkg::ADDR_CTRL: next_rdata = {22'h0, ctrl};
        counter_pkg::ADDR_PRESCALE: next_rdata = prescale;
        counter_pkg::ADDR_PRESET1: next_rdata = preset1;
        counter_pkg::ADDR_PRESET2: next_rdata = preset2;
        counter_pkg::ADDR_OUT_TIME: next_rdata = out_time;
        counter_pkg::ADDR_COUNT: next_rdata = count;
        counter_pkg::ADDR_SECOND: next_rdata = second;
        counter_pkg::ADDR_STATUS: next_rdata = {28'h0, status};
        counter_pkg::ADDR_MASK: next_rdata = {28'h0, mask};
        counter_pkg::ADDR_UI: next_rdata = {20'h0, out_o, state, param, view, digit};
        default: next_rdata = 32'h0;
      endcase
    end
    // upper line: count, or parameter code while programming
    next_upper = (state == counter_pkg::UI_PROG) ? {30'h0, param} : count;
    // lower line: edit value, option value or viewed value
    case (state)
      counter_pkg::UI_EDIT: next_lower = edit_val;
      counter_pkg::UI_PROG: begin
        case (param)
          counter_pkg::PARAM_COUNT_INPUT_CONFIG: next_lower = {31'h0, single_dir};
          counter_pkg::PARAM_DIR: next_lower = {31'h0, count_down};
          counter_pkg::PARAM_AUTORST: next_lower = {30'h0, autorst};
          default: next_lower = {31'h0, ctrl[counter_pkg::CTRL_SCROLL]};
        endcase
      end
      default: next_lower = view_value;
    endcase
    // outputs, direction and one flag per viewed value except out_time, which has none
    next_annun = {view == counter_pkg::VIEW_SECOND, view == counter_pkg::VIEW_PRESET2,
      view == counter_pkg::VIEW_PRESET1, view == counter_pkg::VIEW_PRESCALE,
      dir_down, next_out};
  end

  // all state registers
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ctrl <= counter_pkg::CTRL_RESET;
      prescale <= counter_pkg::PRESCALE_RESET;
      preset1 <= counter_pkg::ZERO_RESET;
      preset2 <= counter_pkg::ZERO_RESET;
      out_time <= counter_pkg::ZERO_RESET;
      count <= counter_pkg::ZERO_RESET;
      second <= counter_pkg::ZERO_RESET;
      out_o <= 2'h0;
      eq1_q <= 1'b1;
      eq2_q <= 1'b1;
      status <= '0;
      mask <= '0;
      irq_o <= 1'b0;
      state <= counter_pkg::UI_OPERATE;
      view <= counter_pkg::VIEW_PRESCALE;
      digit <= 3'h0;
      edit_val <= counter_pkg::ZERO_RESET;
      idle <= '0;
      hold <= '0;
      param <= counter_pkg::PARAM_COUNT_INPUT_CONFIG;
      rdata_o <= 32'h0;
      upper_value_o <= 32'h0;
      upper_is_mnemonic_o <= 1'b0;
      lower_value_o <= 32'h0;
      annunciator_o <= 7'h0;
      edit_digit_o <= 3'h0;
      edit_active_o <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      prescale <= next_prescale;
      preset1 <= next_preset1;
      preset2 <= next_preset2;
      out_time <= next_out_time;
      count <= next_count;
      second <= next_second;
      out_o <= next_out;
      eq1_q <= (count == preset1);
      eq2_q <= (count == preset2);
      status <= next_status;
      mask <= next_mask;
      irq_o <= |(next_status & next_mask);
      state <= next_state;
      view <= next_view;
      digit <= next_digit;
      edit_val <= next_edit;
      idle <= next_idle;
      hold <= next_hold;
      param <= next_param;
      rdata_o <= next_rdata;
      upper_value_o <= next_upper;
      upper_is_mnemonic_o <= (state == counter_pkg::UI_PROG);
      lower_value_o <= next_lower;
      annunciator_o <= next_annun;
      edit_digit_o <= next_digit;
      edit_active_o <= (next_state == counter_pkg::UI_EDIT);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  chk_reset_load: assert property (manual_reset |=>
    count == ($past(count_down) ? $past(preset1) : 32'h0))
    else $error("reset loaded wrong value");
  chk_count_step: assert property (count_edge && !any_reset |=> count ==
    ($past(dir_down) ? $past(count) - $past(prescale) : $past(count) + $past(prescale)))
    else $error("count step wrong");
  chk_out_set: assert property (match1_ev |=> out_o[0] && status[counter_pkg::ST_MATCH1])
    else $error("preset match did not set output");
  chk_batch_inc: assert property (!total_mode && cycle_done && !bus_wr_second
    |=> second == $past(second) + 32'h1)
    else $error("batch count did not step by one");
  chk_total_hold: assert property (total_mode && !count_edge && !bus_wr_second
    |=> $stable(second))
    else $error("total changed without count edge");
  chk_edit_timeout: assert property (state == counter_pkg::UI_EDIT && !any_key && !wr_i
    && idle == IW'(EDIT_TIMEOUT_CYC - 1) |=> state == counter_pkg::UI_OPERATE
    && $stable(preset1) && $stable(prescale))
    else $error("idle edit not abandoned");
  chk_irq_level: assert property (##1 irq_o == |(status & mask))
    else $error("interrupt level mismatch");
  cov_commit: cover property (state == counter_pkg::UI_EDIT ##1 ui_commit);
  cov_batch: cover property (cycle_done && !total_mode);
  cov_prog: cover property (state == counter_pkg::UI_PROG && ui_opt_step);
endmodule : preset_batch_pulse_counter

//--- pulse_sensor_model.sv
`timescale 1ns/1ps
module pulse_sensor_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [7:0] width_i,
  output logic pin_o
);
  // cycles of high level still to come
  logic [7:0] left = 8'h00;
  // one high pulse per go, width chosen by the bench
  always_ff @(posedge clk_i) begin
    if (go_i) begin
      left <= width_i;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
  // sensor output idles low between pulses
  assign pin_o = (left != 8'h00);
endmodule : pulse_sensor_model

//--- test_preset_batch_pulse_counter.sv
`timescale 1ns/1ps
module test_preset_batch_pulse_counter;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic user_i = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic go = 1'b0;
  logic dir_b = 1'b0; // input B direction level
  logic mnem;
  logic editing;
  logic [2:0] digit;
  logic [3:0] key = 4'h0; // func, menu, up, right
  logic [6:0] annun;
  logic [31:0] upper;
  logic [31:0] lower;
  logic pin_a;
  logic irq_o;
  logic [1:0] out_o;
  logic [7:0] addr = 8'h00;
  logic [7:0] width = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata_o;
  int fail_count = 0;
  int checks_done = 0;
  // short filter and hold counts keep the run brief
  preset_batch_pulse_counter #(.DEBOUNCE_CYC(8), .MENU_HOLD_CYC(20), .EDIT_TIMEOUT_CYC(50))
    preset_batch_pulse_counter_i (.clk_i(clk_i), .rstn_i(rstn_i), .count_a_i(pin_a),
    .count_b_i(dir_b), .user_i(user_i), .key_func_i(key[0]), .key_menu_i(key[1]),
    .key_up_i(key[2]), .key_right_i(key[3]), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata_o), .out_o(out_o), .irq_o(irq_o), .upper_value_o(upper),
    .upper_is_mnemonic_o(mnem), .lower_value_o(lower), .annunciator_o(annun),
    .edit_digit_o(digit), .edit_active_o(editing));
  pulse_sensor_model pulse_sensor_model_i (.clk_i(clk_i), .go_i(go), .width_i(width),
    .pin_o(pin_a));
  // 125 MHz clock
  initial forever #4 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : wr_reg
  // read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask : rd_chk
  // n sensor pulses of w cycles, each followed by a long low gap
  task automatic pulse(input logic [7:0] w, input int n);
    repeat (n) begin
      @(posedge clk_i);
      go <= 1'b1;
      width <= w;
      @(posedge clk_i);
      go <= 1'b0;
      repeat (int'(w) + 30) @(posedge clk_i);
    end
  endtask : pulse
  // user input held at lvl long enough to pass the filter
  task automatic user_pulse(input logic lvl);
    @(posedge clk_i);
    user_i <= lvl;
    repeat (16) @(posedge clk_i);
    user_i <= ~lvl;
    repeat (30) @(posedge clk_i);
  endtask : user_pulse
  // one front key held n cycles, then a 30 cycle release
  task automatic key_press(input logic [1:0] idx, input int n);
    @(posedge clk_i);
    key <= 4'h1 << idx;
    repeat (n) @(posedge clk_i);
    key <= 4'h0;
    repeat (30) @(posedge clk_i);
  endtask : key_press
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  initial begin
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd_chk(8'h00, 32'h0000_0081);
    rd_chk(8'h04, 32'h0000_0001);
    rd_chk(8'h30, 32'h0000_0000);
    wr_reg(8'h04, 32'h0000_0005);
    wr_reg(8'h0C, 32'h0000_0064);
    wr_reg(8'h08, 32'h0000_000F);
    wr_reg(8'h20, 32'h0000_0001);
    wr_reg(8'h00, 32'h0000_0007);
    pulse(8'h04, 3);
    for (int i = 0; i < 50 && out_o[0] !== 1'b1; i++) @(posedge clk_i);
    if (out_o[0] !== 1'b1) begin
      fail_count++;
      complete_run();
    end
    #1 chk({31'h0, irq_o}, 32'h1);
    rd_chk(8'h14, 32'h0000_000F);
    wr_reg(8'h1C, 32'h0000_0001);
    repeat (2) @(posedge clk_i);
    #1 chk({31'h0, irq_o}, 32'h0);
    user_pulse(1'b1);
    chk({30'h0, out_o}, 32'h0);
    rd_chk(8'h14, 32'h0000_0000);
    wr_reg(8'h00, 32'h0000_0017);
    user_pulse(1'b1);
    rd_chk(8'h14, 32'h0000_000F);
    wr_reg(8'h00, 32'h0000_0006);
    user_i <= 1'b1;
    pulse(8'h04, 1);
    rd_chk(8'h14, 32'h0000_0014);
    user_pulse(1'b0);
    rd_chk(8'h14, 32'h0000_0000);
    wr_reg(8'h00, 32'h0000_0001);
    user_i <= 1'b0;
    pulse(8'h03, 1);
    rd_chk(8'h14, 32'h0000_0000);
    pulse(8'h0C, 1);
    rd_chk(8'h14, 32'h0000_0005);
    wr_reg(8'h18, 32'h0000_0000);
    wr_reg(8'h0C, 32'h0000_000A);
    wr_reg(8'h00, 32'h0000_0047);
    user_pulse(1'b1);
    pulse(8'h04, 4);
    rd_chk(8'h18, 32'h0000_0002);
    rd_chk(8'h14, 32'h0000_0000);
    wr_reg(8'h00, 32'h0000_0147);
    wr_reg(8'h18, 32'h0000_0000);
    pulse(8'h04, 3);
    rd_chk(8'h18, 32'h0000_000F);
    // front panel: view, edit, commit, idle abandon
    key_press(2'h1, 16);
    #1 chk(lower, 32'h0000_000F);
    chk({25'h0, annun}, 32'h0000_0012);
    key_press(2'h2, 16);
    key_press(2'h2, 16);
    #1 chk(lower, 32'h0000_0010);
    chk({31'h0, editing}, 32'h1);
    key_press(2'h3, 16);
    #1 chk({29'h0, digit}, 32'h1);
    key_press(2'h2, 16);
    key_press(2'h1, 16);
    rd_chk(8'h08, 32'h0000_001A);
    key_press(2'h2, 16);
    key_press(2'h2, 16);
    repeat (30) @(posedge clk_i);
    #1 chk({31'h0, editing}, 32'h0);
    rd_chk(8'h08, 32'h0000_001A);
    // function key reset, then counting down by input B
    wr_reg(8'h00, 32'h0000_01C7);
    dir_b <= 1'b1;
    key_press(2'h0, 16);
    rd_chk(8'h14, 32'h0000_0000);
    pulse(8'h04, 1);
    rd_chk(8'h14, 32'hFFFF_FFFB);
    rd_chk(8'h18, 32'h0000_000A);
    chk(upper, 32'hFFFF_FFFB);
    // long menu hold enters programming
    key_press(2'h1, 40);
    #1 chk({31'h0, mnem}, 32'h1);
    chk(upper, 32'h0000_0000);
    key_press(2'h2, 16);
    rd_chk(8'h00, 32'h0000_01CF);
    repeat (4) key_press(2'h1, 16);
    #1 chk({31'h0, mnem}, 32'h0);
    complete_run();
  end
endmodule : test_preset_batch_pulse_counter
